/* src/lhhmc_top.v */
// Holdover for both loops, hitless switching for the main loop, mode control for the secondary loop
`timescale 1ns/1ps
`include "lhhmc_consts.vh"
module lhhmc_top #(
  parameter SEC_CYCLES = `LHHMC_HIST_TICK_S * `LHHMC_CLK_HZ
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Main loop datapath
  input  wire [39:0] mainFreqIn,
  input  wire        mainLocked,
  input  wire        mainHoldover,
  input  wire        mainFreeRun,
  input  wire [3:0]  mainRefSel,
  input  wire [31:0] mainPhaseErr,
  output reg  [39:0] mainFreqOut,
  output wire [31:0] mainPhaseComp,
  output wire [23:0] mainSlopeLimit,
  output reg         hitlessEvent,
  // Secondary loop datapath
  input  wire        secInSelected,
  input  wire        secSelDisq,
  input  wire        secHigherSwitch,
  input  wire        secForcedSwitch,
  input  wire [39:0] secIntegral,
  output reg  [39:0] secFreqOut,
  output wire [1:0]  secState,
  output wire        secRelock,
  output wire        secEnabled,
  // Sync pins and pulses
  input  wire [5:0]  inPin,
  output reg  [5:0]  syncPulse,
  output wire [1:0]  syncRate
);

  reg  [`LHHMC_CTRL_W-1:0] ctrl_r;     // Control register
  reg  [39:0]              hoWord_r;   // Software holdover word
  reg  [23:0]              progSlope_r;// Programmable slope
  reg  [31:0]              hardLim_r;  // Hard frequency limit
  reg  [23:0]              syncSel_r;  // Six 4-bit sync selects
  reg  [39:0]              avg_r;      // Averaged main frequency
  reg  [39:0]              hist1_r;    // Average one tick back
  reg  [39:0]              hist8_r;    // Average eight ticks back
  reg  [39:0]              hist64_r;   // Average 64 ticks back
  reg  [39:0]              acq_nxt;    // Acquired holdover value
  reg  [5:0]               avgShift;   // Bandwidth shift
  reg  [31:0]              secCnt_r;   // Tick divider
  reg  [5:0]               tickCnt_r;  // Ticks seen
  reg                      tick_r;     // History tick pulse
  reg  [3:0]               refSel_r;   // Previous reference
  reg                      wasIdle_r;  // Previous holdover or free-run
  reg  [31:0]              compHeld_r; // Held compensation target
  reg  [5:0]               pinA_r;     // Pin sync stage one
  reg  [5:0]               pinB_r;     // Pin sync stage two
  reg  [31:0]              rdata_nxt;  // Read mux
  reg                      mapped;     // Address decodes
  wire                     setup;      // Setup phase
  wire                     wrEn;       // Write strobe
  wire                     hsTrig;     // Raw hitless trigger
  wire [39:0]              limExt;     // Hard limit widened
  wire [31:0]              phaseTarget;// Limiter target
  wire                     secEnable;  // Secondary loop enabled
  wire [39:0]              secHold;    // Secondary holdover value

  // Signed clamp to +/- limit
  function [39:0] clampF;
    input [39:0] v;
    input [39:0] lim;
    begin
      if ($signed(v) > $signed(lim))
        clampF = lim;
      else if ($signed(v) < -$signed(lim))
        clampF = 40'h00_0000_0000 - lim;
      else
        clampF = v;
    end
  endfunction

  // APB: zero wait states, error on unmapped address
  assign setup   = psel & ~penable;
  assign wrEn    = psel & penable & pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign limExt  = {8'h00, hardLim_r};

  assign secEnable  = ~ctrl_r[`LHHMC_B_PDN];
  assign secEnabled = secEnable;
  assign syncRate   = ctrl_r[`LHHMC_F_SRATE];

  // Address decode
  always @* begin
    case (paddr)
      `LHHMC_OFF_CTRL, `LHHMC_OFF_HO_LO, `LHHMC_OFF_HO_HI, `LHHMC_OFF_PROG,
      `LHHMC_OFF_HLIM, `LHHMC_OFF_SYNC, `LHHMC_OFF_STAT, `LHHMC_OFF_PHASE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Register writes
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r      <= `LHHMC_CTRL_RST;
      hoWord_r    <= 40'h00_0000_0000;
      progSlope_r <= 24'h00_0000;
      hardLim_r   <= 32'hFFFF_FFFF;
      syncSel_r   <= 24'h00_0000;
    end else if (wrEn) begin
      case (paddr)
        `LHHMC_OFF_CTRL:  ctrl_r         <= pwdata[`LHHMC_CTRL_W-1:0];
        `LHHMC_OFF_HO_LO: hoWord_r[31:0] <= pwdata;
        `LHHMC_OFF_HO_HI: hoWord_r[39:32]<= pwdata[7:0];
        `LHHMC_OFF_PROG:  progSlope_r    <= pwdata[23:0];
        `LHHMC_OFF_HLIM:  hardLim_r      <= pwdata;
        `LHHMC_OFF_SYNC:  syncSel_r      <= pwdata[23:0];
        default:          ;
      endcase
    end
  end

  // Read data mux
  always @* begin
    case (paddr)
      `LHHMC_OFF_CTRL:  rdata_nxt = {13'h0000, ctrl_r};
      // Acquired or written word
      `LHHMC_OFF_HO_LO: rdata_nxt = ctrl_r[`LHHMC_B_RDAVG] ? acq_nxt[31:0] : hoWord_r[31:0];
      `LHHMC_OFF_HO_HI: rdata_nxt = {24'h00_0000, ctrl_r[`LHHMC_B_RDAVG] ? acq_nxt[39:32] : hoWord_r[39:32]};
      `LHHMC_OFF_PROG:  rdata_nxt = {8'h00, progSlope_r};
      `LHHMC_OFF_HLIM:  rdata_nxt = hardLim_r;
      `LHHMC_OFF_SYNC:  rdata_nxt = {8'h00, syncSel_r};
      `LHHMC_OFF_STAT:  rdata_nxt = {27'h000_0000, secRelock, secEnable, mainHoldover, secState};
      `LHHMC_OFF_PHASE: rdata_nxt = mainPhaseComp;
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase
  always @(posedge clk_sys) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rdata_nxt;
  end

  // History tick divider
  always @(posedge clk_sys) begin
    if (rst) begin
      secCnt_r  <= 32'h0000_0000;
      tickCnt_r <= 6'h00;
      tick_r    <= 1'b0;
    end else if (secCnt_r == SEC_CYCLES - 1) begin
      secCnt_r  <= 32'h0000_0000;
      tickCnt_r <= tickCnt_r + 6'h01;
      tick_r    <= 1'b1;
    end else begin
      secCnt_r  <= secCnt_r + 32'h0000_0001;
      tick_r    <= 1'b0;
    end
  end

  // Averaging bandwidth select
  always @* begin
    case (ctrl_r[`LHHMC_F_AVG])
      2'h0:    avgShift = `LHHMC_SH_018M;
      2'h1:    avgShift = `LHHMC_SH_15M;
      2'h2:    avgShift = `LHHMC_SH_12M;
      default: avgShift = `LHHMC_SH_015;
    endcase
  end

  // Averaging and history while locked
  always @(posedge clk_sys) begin
    if (rst) begin
      avg_r    <= 40'h00_0000_0000;
      hist1_r  <= 40'h00_0000_0000;
      hist8_r  <= 40'h00_0000_0000;
      hist64_r <= 40'h00_0000_0000;
    end else if (mainLocked) begin
      avg_r <= $signed(avg_r) + ($signed(mainFreqIn - avg_r) >>> avgShift);
      if (tick_r) begin
        hist1_r <= avg_r;
        if (tickCnt_r[2:0] == `LHHMC_HIST_MID_CNT)
          hist8_r <= avg_r;
        if (tickCnt_r == `LHHMC_HIST_LONG_CNT)
          hist64_r <= avg_r;
      end
    end
  end

  // Acquired holdover value
  always @* begin
    if (!ctrl_r[`LHHMC_B_AUTO]) begin
      acq_nxt = avg_r;
    end else begin
      case (ctrl_r[`LHHMC_F_HIST])
        `LHHMC_HIST_NOW: acq_nxt = avg_r;
        `LHHMC_HIST_1S:  acq_nxt = hist1_r;
        `LHHMC_HIST_8S:  acq_nxt = hist8_r;
        default:         acq_nxt = hist64_r;
      endcase
    end
  end

  // Main frequency out, clamped
  always @(posedge clk_sys) begin
    if (rst)
      mainFreqOut <= 40'h00_0000_0000;
    else if (mainHoldover)
      // Signed word as offset
      mainFreqOut <= clampF(ctrl_r[`LHHMC_B_MAN] ? hoWord_r : acq_nxt, limExt);
    else
      mainFreqOut <= clampF(mainFreqIn, limExt);
  end

  // Hitless trigger
  assign hsTrig = (mainRefSel != refSel_r) ||
                  (wasIdle_r && !(mainHoldover || mainFreeRun));

  // Hitless event and held compensation
  always @(posedge clk_sys) begin
    if (rst) begin
      refSel_r     <= 4'h0;
      wasIdle_r    <= 1'b0;
      hitlessEvent <= 1'b0;
      compHeld_r   <= 32'h0000_0000;
    end else begin
      refSel_r     <= mainRefSel;
      wasIdle_r    <= mainHoldover | mainFreeRun;
      // Freeze ignores events
      hitlessEvent <= ctrl_r[`LHHMC_B_HSEN] && !ctrl_r[`LHHMC_B_HSFRZ] && hsTrig;
      if (ctrl_r[`LHHMC_B_HSEN] && !ctrl_r[`LHHMC_B_HSFRZ] && hsTrig)
        compHeld_r <= mainPhaseErr;
    end
  end

  // Hold offset or walk to zero
  assign phaseTarget = ctrl_r[`LHHMC_B_HSEN] ? compHeld_r : 32'h0000_0000;

  // Event loads compensation at once
  lhhmc_slope_lim uSlope (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .slopeSel  (ctrl_r[`LHHMC_F_SLOPE]),
    .progSlope (progSlope_r),
    .stepTick  (tick_r),
    .loadEn    (hitlessEvent),
    .loadVal   (compHeld_r),
    .target    (phaseTarget),
    .phase_r   (mainPhaseComp),
    .limit_r   (mainSlopeLimit)
  );

  // Secondary loop mode machine
  lhhmc_sec_fsm uSec (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .powerdown    (ctrl_r[`LHHMC_B_PDN]),
    .modeSel      (ctrl_r[`LHHMC_F_MODE]),
    .avgSel       (ctrl_r[`LHHMC_B_SAVG]),
    .inSelected   (secInSelected),
    .selDisq      (secSelDisq),
    .higherSwitch (secHigherSwitch),
    .forcedSwitch (secForcedSwitch),
    .integral     (secIntegral),
    .state_r      (secState),
    .relock_r     (secRelock),
    .hold_r       (secHold)
  );

  // Secondary frequency per state
  always @(posedge clk_sys) begin
    if (rst) begin
      secFreqOut <= 40'h00_0000_0000;
    end else begin
      case (secState)
        `LHHMC_ST_LOCK: secFreqOut <= clampF(secIntegral, limExt);
        `LHHMC_ST_HOLD: secFreqOut <= clampF(secHold, limExt);
        default:        secFreqOut <= 40'h00_0000_0000;
      endcase
    end
  end

  // Pin synchronisers
  always @(posedge clk_sys) begin
    if (rst) begin
      pinA_r <= 6'h00;
      pinB_r <= 6'h00;
    end else begin
      pinA_r <= inPin;
      pinB_r <= pinA_r;
    end
  end

  // Per-input sync pin selection
  genvar gi;
  generate
    for (gi = 0; gi < `LHHMC_NIN; gi = gi + 1) begin : gSync
      wire [3:0] sel;
      assign sel = syncSel_r[gi*`LHHMC_SEL_W +: `LHHMC_SEL_W];
      always @(posedge clk_sys) begin
        if (rst)
          syncPulse[gi] <= 1'b0;
        else if (sel < `LHHMC_NIN)
          syncPulse[gi] <= pinB_r[sel[2:0]];
        else
          syncPulse[gi] <= 1'b0;
      end
    end
  endgenerate
endmodule

/* src/lhhmc_consts.vh */
// Constants for the loop holdover, hitless and mode control block
//
// Summary of operation
// - Main holdover uses stored frequency, no lock
// - History now/1/8/64 s, four averaging bandwidths
// - Reset default: current average, 1.5 mHz
// - Manual holdover uses software 40-bit word
// - Read-select picks acquired or written word
// - Holdover word is signed, +/-92 ppm
// - LSB weighs 77760/1638400 times 2^-48 ppm
// - Hitless event measures and compensates phase
// - Event on reference change or leaving holdover or free-run
// - Hitless phase transient at most 0.61 ns
// - Freeze ignores events, holds compensation
// - Disabled hitless drifts to zero, slope-limited
// - Three-bit select picks phase slope limit
// - Programmable limit is 24 bits, 1484.3614 us/s
// - Both loops clamp to hard frequency limit
// - Three-bit field selects secondary loop mode
// - Secondary loop powered down until enabled
// - Automatic machine acts on selection events
// - Free-run ignores every input reference
// - Locked mode tracks selected input
// - Average select 0 captures integral value
// - Average select 1 uses 1.5 mHz average
// - Per-input 4-bit sync pin select
`ifndef LHHMC_CONSTS_VH
`define LHHMC_CONSTS_VH

// Clock and history timing
`define LHHMC_CLK_HZ        200000000
`define LHHMC_HIST_TICK_S   1
`define LHHMC_HIST_MID_CNT  3'h7
`define LHHMC_HIST_LONG_CNT 6'h3F

// Register byte offsets
`define LHHMC_OFF_CTRL      8'h00
`define LHHMC_OFF_HO_LO     8'h04
`define LHHMC_OFF_HO_HI     8'h08
`define LHHMC_OFF_PROG      8'h0C
`define LHHMC_OFF_HLIM      8'h10
`define LHHMC_OFF_SYNC      8'h14
`define LHHMC_OFF_STAT      8'h18
`define LHHMC_OFF_PHASE     8'h1C

// Control register fields
`define LHHMC_B_MAN         0
`define LHHMC_B_AUTO        1
`define LHHMC_F_HIST        3:2
`define LHHMC_F_AVG         5:4
`define LHHMC_B_RDAVG       6
`define LHHMC_B_HSEN        7
`define LHHMC_B_HSFRZ       8
`define LHHMC_F_SLOPE       11:9
`define LHHMC_B_PDN         12
`define LHHMC_F_MODE        15:13
`define LHHMC_B_SAVG        16
`define LHHMC_F_SRATE       18:17
`define LHHMC_CTRL_W        19
`define LHHMC_CTRL_RST      19'h0_1E12

// History depth codes
`define LHHMC_HIST_NOW      2'h0
`define LHHMC_HIST_1S       2'h1
`define LHHMC_HIST_8S       2'h2

// Averaging shifts, one per bandwidth code
`define LHHMC_SH_018M       6'h14
`define LHHMC_SH_15M        6'h11
`define LHHMC_SH_12M        6'h0E
`define LHHMC_SH_015        6'h0A

// Slope limit select codes and values, LSB 1484.3614 us/s / 2^24
`define LHHMC_SL_61U        3'h0
`define LHHMC_SL_885N       3'h1
`define LHHMC_SL_7U5        3'h2
`define LHHMC_SL_UNLIM      3'h3
`define LHHMC_SL_1N         3'h4
`define LHHMC_SL_5N         3'h5
`define LHHMC_SL_10N        3'h6
`define LHHMC_V_61U         24'h0A_8534
`define LHHMC_V_885N        24'h00_2713
`define LHHMC_V_7U5         24'h01_4B22
`define LHHMC_V_UNLIM       24'hFF_FFFF
`define LHHMC_V_1N          24'h00_000B
`define LHHMC_V_5N          24'h00_0039
`define LHHMC_V_10N         24'h00_0071

// Secondary loop modes and states
`define LHHMC_MODE_AUTO     3'h0
`define LHHMC_MODE_FREE     3'h1
`define LHHMC_MODE_HOLD     3'h2
`define LHHMC_MODE_LOCK     3'h4
`define LHHMC_ST_FREE       2'h0
`define LHHMC_ST_LOCK       2'h1
`define LHHMC_ST_HOLD       2'h2

// Sync pin count and select width
`define LHHMC_NIN           6
`define LHHMC_SEL_W         4

`endif

/* src/lhhmc_slope_lim.v */
// Phase slope limiter for the main loop compensating phase
`timescale 1ns/1ps
`include "lhhmc_consts.vh"
module lhhmc_slope_lim (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Control
  input  wire [2:0]  slopeSel,
  input  wire [23:0] progSlope,
  input  wire        stepTick,
  input  wire        loadEn,
  input  wire [31:0] loadVal,
  input  wire [31:0] target,
  // Result
  output reg  [31:0] phase_r,
  output reg  [23:0] limit_r
);
  reg  [23:0]        limit_nxt;   // Active limit
  wire signed [32:0] diff;        // Target minus phase
  wire [32:0]        limExt;      // Limit widened

  assign diff   = $signed({target[31], target}) - $signed({phase_r[31], phase_r});
  assign limExt = {9'h000, limit_r};

  // Map select to limit value
  always @* begin
    case (slopeSel)
      `LHHMC_SL_61U:   limit_nxt = `LHHMC_V_61U;
      `LHHMC_SL_885N:  limit_nxt = `LHHMC_V_885N;
      `LHHMC_SL_7U5:   limit_nxt = `LHHMC_V_7U5;
      `LHHMC_SL_UNLIM: limit_nxt = `LHHMC_V_UNLIM;
      `LHHMC_SL_1N:    limit_nxt = `LHHMC_V_1N;
      `LHHMC_SL_5N:    limit_nxt = `LHHMC_V_5N;
      `LHHMC_SL_10N:   limit_nxt = `LHHMC_V_10N;
      default:         limit_nxt = progSlope;
    endcase
  end

  // Direct load, else bounded step toward target
  always @(posedge clk_sys) begin
    limit_r <= limit_nxt;
    if (rst) begin
      phase_r <= 32'h0000_0000;
    end else if (loadEn) begin
      phase_r <= loadVal;
    end else if (stepTick) begin
      // Step clipped to the limit
      if (diff > $signed(limExt))
        phase_r <= phase_r + {8'h00, limit_r};
      else if (diff < -$signed(limExt))
        phase_r <= phase_r - {8'h00, limit_r};
      else
        phase_r <= target;
    end
  end
endmodule

/* src/lhhmc_sec_fsm.v */
// Secondary loop operating mode machine and holdover capture
`timescale 1ns/1ps
`include "lhhmc_consts.vh"
module lhhmc_sec_fsm (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Control
  input  wire        powerdown,
  input  wire [2:0]  modeSel,
  input  wire        avgSel,
  // Selection events
  input  wire        inSelected,
  input  wire        selDisq,
  input  wire        higherSwitch,
  input  wire        forcedSwitch,
  input  wire [39:0] integral,
  // State
  output reg  [1:0]  state_r,
  output reg         relock_r,
  output reg  [39:0] hold_r
);
  reg  [1:0]  state_nxt;  // Next state
  reg  [39:0] avg_r;      // Averaged integral
  wire        reselect;   // Relock trigger

  assign reselect = selDisq | higherSwitch | forcedSwitch;

  // Next state: forced modes override automatic
  always @* begin
    state_nxt = state_r;
    case (modeSel)
      `LHHMC_MODE_FREE: state_nxt = `LHHMC_ST_FREE;
      `LHHMC_MODE_HOLD: state_nxt = `LHHMC_ST_HOLD;
      `LHHMC_MODE_LOCK: state_nxt = `LHHMC_ST_LOCK;
      default: begin
        // Automatic machine
        case (state_r)
          `LHHMC_ST_FREE: if (inSelected) state_nxt = `LHHMC_ST_LOCK;
          `LHHMC_ST_LOCK: if (!inSelected) state_nxt = `LHHMC_ST_HOLD;
          `LHHMC_ST_HOLD: if (inSelected) state_nxt = `LHHMC_ST_LOCK;
          default:        state_nxt = `LHHMC_ST_FREE;
        endcase
      end
    endcase
  end

  // State, averaging and holdover capture
  always @(posedge clk_sys) begin
    if (rst || powerdown) begin
      state_r  <= `LHHMC_ST_FREE;
      relock_r <= 1'b0;
      avg_r    <= 40'h00_0000_0000;
      hold_r   <= 40'h00_0000_0000;
    end else begin
      state_r  <= state_nxt;
      relock_r <= (state_r == `LHHMC_ST_LOCK) && (state_nxt == `LHHMC_ST_LOCK) && reselect;
      if (state_r == `LHHMC_ST_LOCK)
        avg_r <= $signed(avg_r) + ($signed(integral - avg_r) >>> `LHHMC_SH_15M);
      // Capture on entry to holdover
      if (state_r != `LHHMC_ST_HOLD && state_nxt == `LHHMC_ST_HOLD)
        hold_r <= avgSel ? avg_r : integral;
    end
  end
endmodule

/* bench/lhhmc_assertions.sv */
// Checker for hitless, slope and secondary loop ports
`timescale 1ns/1ps
`include "lhhmc_consts.vh"
module lhhmc_assertions (
  // Clock and reset
  input wire        clk_sys,
  input wire        rst,
  // APB writes seen
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  // Watched outputs
  input wire [3:0]  mainRefSel,
  input wire [31:0] mainPhaseErr,
  input wire [31:0] mainPhaseComp,
  input wire [23:0] mainSlopeLimit,
  input wire        hitlessEvent,
  input wire [1:0]  secState,
  input wire        secEnabled
);
  reg [18:0] ctrlShadow_r;  // Copy of the control word

  // Follows every accepted control write
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrlShadow_r <= `LHHMC_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == `LHHMC_OFF_CTRL) begin
      ctrlShadow_r <= pwdata[18:0];
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Slope code steady long enough for the limit to follow
  sequence slopeHeld(logic [2:0] code);
    (ctrlShadow_r[11:9] == code) [*3];
  endsequence
  // Secondary loop enabled and forced to one mode
  sequence modeHeld(logic [2:0] m);
    (ctrlShadow_r[15:13] == m && !ctrlShadow_r[12]) [*3];
  endsequence

  a_hitless_gate: assert property (hitlessEvent |-> $past(ctrlShadow_r[7] && !ctrlShadow_r[8]))
    else $error("hitless event while disabled or frozen");
  a_switch_event: assert property ($changed(mainRefSel) && ctrlShadow_r[7] && !ctrlShadow_r[8]
    |-> ##[1:2] hitlessEvent)
    else $error("reference change without hitless event");
  a_comp_capture: assert property (hitlessEvent |-> ##[1:2] (mainPhaseComp == mainPhaseErr))
    else $error("measured phase not compensated");
  a_freeze_holds: assert property ((ctrlShadow_r[8] && ctrlShadow_r[7]) [*2] |=> $stable(mainPhaseComp))
    else $error("phase moved while frozen");
  a_slope_unlim: assert property (slopeHeld(`LHHMC_SL_UNLIM) |-> mainSlopeLimit == `LHHMC_V_UNLIM)
    else $error("unlimited slope value wrong");
  a_slope_fine: assert property (slopeHeld(`LHHMC_SL_1N) |-> mainSlopeLimit == `LHHMC_V_1N)
    else $error("1 ns/s slope value wrong");
  a_sec_enable: assert property (secEnabled != ctrlShadow_r[`LHHMC_B_PDN])
    else $error("secondary enable does not follow powerdown");
  a_powered_down: assert property ((!secEnabled) [*2] |-> secState == `LHHMC_ST_FREE)
    else $error("powered down loop not in free-run");
  a_forced_hold: assert property (modeHeld(`LHHMC_MODE_HOLD) |-> secState == `LHHMC_ST_HOLD)
    else $error("forced holdover not taken");
  a_forced_free: assert property (modeHeld(`LHHMC_MODE_FREE) |-> secState == `LHHMC_ST_FREE)
    else $error("forced free-run not taken");
endmodule

bind lhhmc_top lhhmc_assertions i_lhhmc_assertions (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .mainRefSel(mainRefSel), .mainPhaseErr(mainPhaseErr),
  .mainPhaseComp(mainPhaseComp), .mainSlopeLimit(mainSlopeLimit), .hitlessEvent(hitlessEvent),
  .secState(secState), .secEnabled(secEnabled)
);

/* bench/lhhmc_top_tb.sv */
// Self-checking testbench for the holdover, hitless and mode control block
`timescale 1ns/1ps
`include "lhhmc_consts.vh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module lhhmc_top_tb;
  logic        clk_sys = 0, rst = 1;                      // Clock and reset
  logic        psel = 0, penable = 0, pwrite = 0;         // APB request
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, mainPhaseErr = 0, rdData, cycles = 0;
  logic        mainLocked = 0, mainHoldover = 0, mainFreeRun = 0, errSeen;
  logic [3:0]  mainRefSel = 0;
  logic        secInSelected = 0, secSelDisq = 0, secHigherSwitch = 0, secForcedSwitch = 0;
  logic [39:0] mainFreqIn = 40'h00_0000_0042, secIntegral = 0;
  logic [5:0]  inPin = 0;
  wire  [31:0] prdata, mainPhaseComp;                     // Outputs
  wire         pready, pslverr, hitlessEvent, secRelock, secEnabled;
  wire  [39:0] mainFreqOut, secFreqOut;
  wire  [23:0] mainSlopeLimit;
  wire  [1:0]  secState, syncRate;
  wire  [5:0]  syncPulse;
  int          compares = 0, miscompares = 0;

  lhhmc_top #(.SEC_CYCLES(20)) i_lhhmc_top (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mainFreqIn(mainFreqIn),
    .mainLocked(mainLocked), .mainHoldover(mainHoldover), .mainFreeRun(mainFreeRun),
    .mainRefSel(mainRefSel), .mainPhaseErr(mainPhaseErr), .mainFreqOut(mainFreqOut),
    .mainPhaseComp(mainPhaseComp), .mainSlopeLimit(mainSlopeLimit), .hitlessEvent(hitlessEvent),
    .secInSelected(secInSelected), .secSelDisq(secSelDisq), .secHigherSwitch(secHigherSwitch),
    .secForcedSwitch(secForcedSwitch), .secIntegral(secIntegral), .secFreqOut(secFreqOut),
    .secState(secState), .secRelock(secRelock), .secEnabled(secEnabled), .inPin(inPin),
    .syncPulse(syncPulse), .syncRate(syncRate)
  );

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // Cuts a hung run short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      final_report;
    end
  end

  // One APB transfer, setup then access until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdData = prdata;
    errSeen = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rd(input logic [7:0] a); apb(1'b0, a, 32'h0000_0000); endtask
  task cyc(input int n); repeat (n) @(posedge clk_sys); endtask

  // Pulse seen within six cycles: 0 hitless event, 1 relock
  task waitHi(input int which, output logic s);
    s = 1'b0;
    repeat (6) begin
      @(posedge clk_sys);
      if ((which ? secRelock : hitlessEvent) === 1'b1) s = 1'b1;
    end
  endtask
  // Bounded wait for a phase value
  task waitComp(input logic [31:0] v);
    int n;
    for (n = 0; n < 200 && mainPhaseComp !== v; n++) @(posedge clk_sys);
  endtask

  // Reset values and an unmapped access
  task t_reset;
    begin
      rd(`LHHMC_OFF_CTRL);
      `CHK("ctrl", 32'h0000_1E12, rdData)
      `CHK("secEn", 1'b0, secEnabled)
      `CHK("limit", 24'h00_0000, mainSlopeLimit)
      rd(8'h20);
      `CHK("slverr", 1'b1, errSeen)
    end
  endtask

  // Manual holdover word, sign, readback and hard limit clamp
  task t_manual;
    begin
      wr(`LHHMC_OFF_HO_LO, 32'hFFFF_FF00);
      wr(`LHHMC_OFF_HO_HI, 32'h0000_00FF);
      wr(`LHHMC_OFF_CTRL, 32'h0000_1E13);
      mainHoldover <= 1'b1;
      cyc(3);
      `CHK("hoNeg", 40'hFF_FFFF_FF00, mainFreqOut)
      wr(`LHHMC_OFF_HO_LO, 32'h0000_1234);
      wr(`LHHMC_OFF_HO_HI, 32'h0000_0000);
      rd(`LHHMC_OFF_HO_LO);
      `CHK("hoRd", 32'h0000_1234, rdData)
      wr(`LHHMC_OFF_CTRL, 32'h0000_1E53);
      rd(`LHHMC_OFF_HO_LO);
      `CHK("hoAcq", 32'h0000_0000, rdData)
      `CHK("hoPos", 40'h00_0000_1234, mainFreqOut)
      wr(`LHHMC_OFF_HLIM, 32'h0000_0100);
      cyc(3);
      `CHK("clamp", 40'h00_0000_0100, mainFreqOut)
      wr(`LHHMC_OFF_HLIM, 32'hFFFF_FFFF);
      mainHoldover <= 1'b0;
    end
  endtask

  // Every slope code, then the programmable value
  task t_slope;
    logic [23:0] tbl [7];
    begin
      tbl = '{`LHHMC_V_61U, `LHHMC_V_885N, `LHHMC_V_7U5, `LHHMC_V_UNLIM, `LHHMC_V_1N, `LHHMC_V_5N, `LHHMC_V_10N};
      for (int i = 0; i < 7; i++) begin
        wr(`LHHMC_OFF_CTRL, 32'h0000_1012 | (i << 9));
        cyc(3);
        `CHK("limit", tbl[i], mainSlopeLimit)
      end
      wr(`LHHMC_OFF_PROG, 32'h0012_3456);
      wr(`LHHMC_OFF_CTRL, 32'h0000_1E12);
      cyc(3);
      `CHK("prog", 24'h12_3456, mainSlopeLimit)
    end
  endtask

  // Hitless on switch and exit, freeze, then disabled drift
  task t_hitless;
    logic s;
    begin
      wr(`LHHMC_OFF_CTRL, 32'h0000_1692);
      mainLocked <= 1'b1;
      mainPhaseErr <= 32'h0000_0400;
      mainRefSel <= 4'h1;
      waitHi(0, s);
      `CHK("evRef", 1'b1, s)
      waitComp(32'h0000_0400);
      `CHK("comp", 32'h0000_0400, mainPhaseComp)
      wr(`LHHMC_OFF_CTRL, 32'h0000_1792);
      mainPhaseErr <= 32'h0000_0800;
      mainRefSel <= 4'h2;
      waitHi(0, s);
      `CHK("evFrz", 1'b0, s)
      `CHK("compFrz", 32'h0000_0400, mainPhaseComp)
      wr(`LHHMC_OFF_CTRL, 32'h0000_1692);
      mainFreeRun <= 1'b1;
      cyc(8);
      mainFreeRun <= 1'b0;
      waitHi(0, s);
      `CHK("evExit", 1'b1, s)
      wr(`LHHMC_OFF_CTRL, 32'h0000_1612);
      mainRefSel <= 4'h3;
      waitHi(0, s);
      `CHK("evOff", 1'b0, s)
      waitComp(32'h0000_0000);
      `CHK("drift", 32'h0000_0000, mainPhaseComp)
    end
  endtask

  // Secondary loop automatic walk, relock causes, forced modes
  task t_sec;
    logic s;
    logic [2:0] md [3];
    logic [1:0] st [3];
    begin
      md = '{`LHHMC_MODE_FREE, `LHHMC_MODE_HOLD, `LHHMC_MODE_LOCK};
      st = '{`LHHMC_ST_FREE, `LHHMC_ST_HOLD, `LHHMC_ST_LOCK};
      wr(`LHHMC_OFF_CTRL, 32'h0000_0012);
      cyc(2);
      `CHK("secEn", 1'b1, secEnabled)
      `CHK("free", `LHHMC_ST_FREE, secState)
      secIntegral <= 40'h00_0123_4567;
      secInSelected <= 1'b1;
      cyc(3);
      `CHK("lock", `LHHMC_ST_LOCK, secState)
      for (int k = 0; k < 3; k++) begin
        {secSelDisq, secHigherSwitch, secForcedSwitch} <= 3'b100 >> k;
        @(posedge clk_sys);
        {secSelDisq, secHigherSwitch, secForcedSwitch} <= 3'b000;
        waitHi(1, s);
        `CHK("relock", 1'b1, s)
      end
      secInSelected <= 1'b0;
      cyc(3);
      `CHK("hold", `LHHMC_ST_HOLD, secState)
      `CHK("hoCap", 40'h00_0123_4567, secFreqOut)
      for (int k = 0; k < 3; k++) begin
        wr(`LHHMC_OFF_CTRL, 32'h0000_0012 | (md[k] << 13));
        cyc(3);
        `CHK("forced", st[k], secState)
      end
      wr(`LHHMC_OFF_CTRL, 32'h0000_1012);
      cyc(3);
      `CHK("pdn", `LHHMC_ST_FREE, secState)
    end
  endtask

  // Sync pin select and sync rate
  task t_sync;
    begin
      wr(`LHHMC_OFF_SYNC, 32'h0000_0003);
      inPin <= 6'b00_1000;
      cyc(5);
      `CHK("syncHi", 1'b1, syncPulse[0])
      inPin <= 6'b11_0111;
      cyc(5);
      `CHK("syncLo", 1'b0, syncPulse[0])
      wr(`LHHMC_OFF_CTRL, 32'h0004_1012);
      cyc(1);
      `CHK("rate", 2'h2, syncRate)
    end
  endtask

  // Prints the counts and the verdict
  task final_report;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_manual;
    t_slope;
    t_hitless;
    t_sec;
    t_sync;
    final_report;
  end
endmodule
